/* src/flash_pkg.sv */
// shared constants and types of the flash program/erase controller
package flash_pkg;
  // timing in printed units and the system clock rate
  localparam int CLK_KHZ   = 20000;
  localparam int PROG_US   = 2;
  localparam int ERASE_MS  = 10;
  // least times round up to whole cycles
  localparam int PROG_CYC  = (PROG_US * CLK_KHZ + 999) / 1000;
  localparam int ERASE_CYC = ERASE_MS * CLK_KHZ;

  // the two array configurations
  localparam int PAGES_SMALL      = 128;
  localparam int PAGE_BYTES_SMALL = 512;
  localparam int PAGES_LARGE      = 256;
  localparam int PAGE_BYTES_LARGE = 1024;

  // erased word value, reset value and command word address width
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [31:0] RDATA_RST   = 32'h00000000;
  localparam int          WADDR_W     = 16;

  typedef enum logic [1:0] {
    OP_PROG,
    OP_PAGE_ERASE,
    OP_MASS_ERASE
  } op_e;

  typedef enum logic {
    SEC_CHECK,
    SEC_RUN
  } sec_e;

  // one command from software or debug
  typedef struct packed {
    logic                 valid;
    op_e                  op;
    logic                 info;
    logic [WADDR_W-1:0]   waddr;
    logic [31:0]          wdata;
  } cmd_s;

  // ahb read request side
  typedef struct packed {
    logic        sel;
    logic [1:0]  trans;
    logic        ready;
    logic [31:0] addr;
    logic        dbg;
  } ahb_req_s;
endpackage : flash_pkg

/* src/flash_program_erase_ctrl.sv */
// flash array with program/erase sequencer, ahb read path and lock check
`timescale 1ns/10ps
// Operation
// (R1) any single main page can be erased alone, other pages untouched
// (R2) erased words read back as all ones
// (R3) programming ANDs data into the word, only an erase restores ones
// (R4) word program keeps the array busy for 2 us
// (R5) page erase keeps the array busy for 10 ms
// (R6) mass erase clears whole main array in 10 ms
// (R7) array reads during an operation hold ready low until it ends
// (R8) masters wanting to run meanwhile must execute from sram
// (R9) commands come from software or debug port
// (R10) information page sits outside main array, mass erase leaves it
// (R11) software should not erase the information page after factory setup
// (R12) last main word is the security word
// (R13) security word checked before core reset release, then debug unlocks
// (R14) protection keeps debug disabled and blocks its memory access
// (R15) idle array answers each ahb read in one cycle
// (R16) small configuration is 128 pages of 512 bytes
// (R17) large configuration is 256 pages of 1 kbyte
// (R18) reads run linearly across page boundaries
// (R19) busy flag set during operation, new commands ignored meanwhile
// (R20) all-ones security word means unprotected, anything else protected
module flash_program_erase_ctrl
  import flash_pkg::*;
#(
  parameter int PAGES      = PAGES_SMALL,
  parameter int PAGE_BYTES = PAGE_BYTES_SMALL,
  parameter int ERASE_N    = ERASE_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // ahb read port
  input  wire ahb_req_s    ahb_req,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // command ports
  input  wire cmd_s        sw_cmd,
  input  wire cmd_s        dbg_cmd,
  // status
  output logic             busy,
  output logic             done,
  output logic             dbg_en,
  output logic             core_rst
);
  localparam int PW_N  = PAGE_BYTES / 4;
  localparam int WORDS = PAGES * PW_N;
  localparam int AW    = $clog2(WORDS);
  localparam int PW    = $clog2(PW_N);
  localparam int CW    = $clog2(ERASE_N + 1);
  localparam int PROG_N = PROG_CYC + 1;
  // only the two supported array organisations are served
  if (!((PAGES == PAGES_SMALL && PAGE_BYTES == PAGE_BYTES_SMALL) ||
        (PAGES == PAGES_LARGE && PAGE_BYTES == PAGE_BYTES_LARGE))) begin : g_cfg_chk
    $error("unsupported flash organisation");
  end
  if (ERASE_N < 1 || ERASE_N < PROG_CYC) begin : g_time_chk
    $error("erase count too small");
  end
  // array storage, nonvolatile so never reset
  logic [31:0]    mem_q  [WORDS];
  logic [31:0]    mem_d  [WORDS];
  logic [31:0]    info_q [PW_N];
  logic [31:0]    info_d [PW_N];
  // sequencer state
  logic           busy_q, busy_d;
  logic           done_q, done_d;
  logic [CW-1:0]  cnt_q, cnt_d;
  op_e            op_q, op_d;
  logic           isel_q, isel_d;
  logic [AW-1:0]  addr_q, addr_d;
  logic [31:0]    wdata_q, wdata_d;
  cmd_s           take;
  logic           go;
  logic           apply;
  // read path state
  logic [31:0]    hrdata_q, hrdata_d;
  logic           hrdy_q, hrdy_d;
  logic           pend_q, pend_d;
  logic [31:0]    paddr_q, paddr_d;
  logic           pdbg_q, pdbg_d;
  logic           acc;
  logic [31:0]    ra;
  logic           rdbg;
  logic [31:0]    rdw;
  // security state
  sec_e           sec_q, sec_d;
  logic           dbg_en_q, dbg_en_d;
  logic           crst_q, crst_d;
  // command selection and operation timing; software wins a tie
  always_comb begin
    busy_d  = busy_q;
    done_d  = 1'b0;
    cnt_d   = cnt_q;
    op_d    = op_q;
    isel_d  = isel_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    go      = 1'b0;
    apply   = 1'b0;
    take    = sw_cmd.valid ? sw_cmd : ((dbg_cmd.valid && dbg_en_q) ? dbg_cmd : '0); // R9 R14
    if (busy_q) begin
      // requests seen while busy are dropped, not queued
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        apply  = 1'b1;
      end else begin
        cnt_d = cnt_q - CW'(1); // R4 R5 R6
      end
    end else if (take.valid && !crst_q) begin // R19
      go      = 1'b1;
      busy_d  = 1'b1;
      op_d    = take.op;
      isel_d  = take.info && (take.op != OP_MASS_ERASE);
      addr_d  = take.waddr[AW-1:0];
      wdata_d = take.wdata;
      cnt_d   = (take.op == OP_PROG) ? CW'(PROG_CYC - 1) : CW'(ERASE_N - 1);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= '0;
      op_q    <= OP_PROG;
      isel_q  <= 1'b0;
      addr_q  <= '0;
      wdata_q <= RDATA_RST;
    end else begin
      busy_q  <= busy_d;
      done_q  <= done_d;
      cnt_q   <= cnt_d;
      op_q    <= op_d;
      isel_q  <= isel_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end
  // array update lands on the same edge that raises done
  always_comb begin
    mem_d  = mem_q;
    info_d = info_q;
    if (apply) begin
      unique case (op_q)
        OP_PROG: begin
          if (isel_q) begin
            info_d[addr_q[PW-1:0]] = info_q[addr_q[PW-1:0]] & wdata_q; // R3
          end else begin
            mem_d[addr_q] = mem_q[addr_q] & wdata_q; // R3
          end
        end
        OP_PAGE_ERASE: begin
          if (isel_q) begin
            for (int i = 0; i < PW_N; i++) begin
              info_d[i] = ERASED_WORD;
            end
          end else begin
            for (int i = 0; i < WORDS; i++) begin
              if ((i / PW_N) == int'(addr_q[AW-1:PW])) begin
                mem_d[i] = ERASED_WORD; // R1 R2 R16 R17
              end
            end
          end
        end
        OP_MASS_ERASE: begin
          // info page is a separate store and is left alone
          for (int i = 0; i < WORDS; i++) begin
            mem_d[i] = ERASED_WORD; // R6 R10
          end
        end
        default: mem_d = mem_q;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    mem_q  <= mem_d;
    info_q <= info_d;
  end

  // read address: pending stalled read first, else the live one
  assign acc  = ahb_req.sel && ahb_req.trans[1] && ahb_req.ready;
  assign ra   = pend_q ? paddr_q : ahb_req.addr;
  assign rdbg = pend_q ? pdbg_q : ahb_req.dbg;

  // word lookup; linear index so pages abut with no gap
  always_comb begin
    if (rdbg && !dbg_en_q) begin
      rdw = RDATA_RST; // R14
    end else if (ra[AW+2]) begin
      rdw = info_q[ra[PW+1:2]];
    end else begin
      rdw = mem_q[ra[AW+1:2]]; // R18 R2
    end
  end

  // read answer; a read during an operation waits with ready low
  always_comb begin
    hrdata_d = hrdata_q;
    hrdy_d   = hrdy_q;
    pend_d   = pend_q;
    paddr_d  = paddr_q;
    pdbg_d   = pdbg_q;
    if (pend_q) begin
      if (!busy_q) begin
        hrdata_d = rdw;
        hrdy_d   = 1'b1;
        pend_d   = 1'b0;
      end
    end else if (acc) begin
      if (busy_q) begin
        hrdy_d  = 1'b0; // R7
        pend_d  = 1'b1;
        paddr_d = ahb_req.addr;
        pdbg_d  = ahb_req.dbg;
      end else begin
        hrdata_d = rdw; // R15
        hrdy_d   = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata_q <= RDATA_RST;
      hrdy_q   <= 1'b1;
      pend_q   <= 1'b0;
      paddr_q  <= RDATA_RST;
      pdbg_q   <= 1'b0;
    end else begin
      hrdata_q <= hrdata_d;
      hrdy_q   <= hrdy_d;
      pend_q   <= pend_d;
      paddr_q  <= paddr_d;
      pdbg_q   <= pdbg_d;
    end
  end

  // lock check: one cycle after reset the last word decides debug
  always_comb begin
    sec_d    = sec_q;
    dbg_en_d = dbg_en_q;
    crst_d   = crst_q;
    unique case (sec_q)
      SEC_CHECK: begin
        // an unknown word falls to the else arm, so it counts as locked
        if (&mem_q[WORDS-1]) begin
          dbg_en_d = 1'b1; // R12 R20
        end else begin
          dbg_en_d = 1'b0; // R14 R20
        end
        crst_d = 1'b0; // R13
        sec_d  = SEC_RUN;
      end
      SEC_RUN: sec_d = SEC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sec_q    <= SEC_CHECK;
      dbg_en_q <= 1'b0;
      crst_q   <= 1'b1;
    end else begin
      sec_q    <= sec_d;
      dbg_en_q <= dbg_en_d;
      crst_q   <= crst_d;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hrdy_q;
  assign hresp     = 1'b0;
  assign busy      = busy_q;
  assign done      = done_q;
  assign dbg_en    = dbg_en_q;
  assign core_rst  = crst_q;
  // helper: length of the busy stretch just ended, zero in reset and when idle
  logic [CW-1:0] len_q;
  always_ff @(posedge sys_clk) begin
    len_q <= (busy_q && !rst) ? CW'(len_q + CW'(1)) : '0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_prog_go;
    go && (take.op == OP_PROG);
  endsequence
  sequence s_main_done(op_e o);
    done_q && (op_q == o) && !isel_q;
  endsequence
  property p_prog_time;
    s_prog_go |=> busy_q ##(PROG_N - 1) (done_q && !busy_q);
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("program time wrong"); // R4
  property p_erase_len;
    done_q && (op_q != OP_PROG) |-> (len_q == CW'(ERASE_N));
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase time wrong"); // R5
  // a read taken in the last busy cycle is still held, though busy has fallen
  property p_stall;
    acc && busy_q && !pend_q |=> !hreadyout && pend_q;
  endproperty
  a_stall: assert property (p_stall) else $error("ready high during operation"); // R7
  property p_single;
    acc && !busy_q && !pend_q |=> hreadyout && (hrdata == $past(rdw));
  endproperty
  a_single: assert property (p_single) else $error("read not single cycle"); // R15
  property p_ignore;
    busy_q && !done_d |=> busy_q && $stable(op_q) && $stable(addr_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("command taken while busy"); // R19
  property p_prog_and;
    s_main_done(OP_PROG) |->
      mem_q[addr_q] == ($past(mem_q[addr_q]) & wdata_q);
  endproperty
  a_prog_and: assert property (p_prog_and) else $error("program not an and"); // R3
  property p_erase_ones;
    s_main_done(OP_PAGE_ERASE) |->
      (mem_q[int'(addr_q[AW-1:PW]) * PW_N] == ERASED_WORD) &&
      (mem_q[int'(addr_q[AW-1:PW]) * PW_N + PW_N - 1] == ERASED_WORD);
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("page not erased"); // R2
  property p_info_keep;
    s_main_done(OP_MASS_ERASE) |-> info_q[0] == $past(info_q[0]);
  endproperty
  a_info_keep: assert property (p_info_keep) else $error("info page touched"); // R10
  property p_lock;
    (sec_q == SEC_CHECK) && !(&mem_q[WORDS-1]) |=> !dbg_en && !core_rst;
  endproperty
  a_lock: assert property (p_lock) else $error("locked part unlocked debug"); // R13
  property p_dbg_block;
    !dbg_en_q && dbg_cmd.valid && !sw_cmd.valid && !busy_q |=> !busy_q;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug command while locked"); // R14
endmodule : flash_program_erase_ctrl

/* bench/ahb_rd_master.sv */
// ahb read master model standing in for the processor on the flash read port
`timescale 1ns/10ps
module ahb_rd_master
  import flash_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // flash read port
  output ahb_req_s         ahb_req,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout
);
  logic        sel_q  = 1'b0;
  logic [31:0] addr_q = 32'h00000000;
  logic        dbg_q  = 1'b0;

  // ready is looped back, as on a bus with this one slave
  assign ahb_req = '{sel: sel_q, trans: {sel_q, 1'b0}, ready: hreadyout,
                     addr: addr_q, dbg: dbg_q};

  // address phase, then hold off until ready comes back high
  task automatic read(input logic [31:0] a, input logic d, output logic [31:0] q,
                      output int waits);
    waits = 0;
    @(posedge sys_clk);
    sel_q  <= 1'b1;
    addr_q <= a;
    dbg_q  <= d;
    @(posedge sys_clk);
    sel_q  <= 1'b0;
    addr_q <= ~a; // released lines never show the old address
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && waits < 2000) begin
      waits++;
      @(posedge sys_clk);
    end
    q = hrdata;
  endtask : read
endmodule : ahb_rd_master

/* bench/flash_program_erase_ctrl_bench.sv */
// self-checking bench of the flash program/erase controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module flash_program_erase_ctrl_bench
  import flash_pkg::*;
();
  localparam int ERASE_SHORT = 50; // short erase keeps the run brief
  localparam int LAST_W      = PAGES_SMALL * PAGE_BYTES_SMALL / 4 - 1;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  cmd_s        sw_cmd  = '0;
  cmd_s        dbg_cmd = '0;
  ahb_req_s    ahb_req;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        busy;
  logic        done;
  logic        dbg_en;
  logic        core_rst;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  logic [31:0] q;
  int          w;

  // 50 ns system clock
  always #25 sys_clk = ~sys_clk;

  flash_program_erase_ctrl #(.PAGES(PAGES_SMALL), .PAGE_BYTES(PAGE_BYTES_SMALL),
                             .ERASE_N(ERASE_SHORT)) dut (
    .sys_clk, .rst, .ahb_req, .hrdata, .hreadyout, .hresp,
    .sw_cmd, .dbg_cmd, .busy, .done, .dbg_en, .core_rst
  );
  ahb_rd_master mst (.sys_clk, .ahb_req, .hrdata, .hreadyout);

  // one command for a single edge; src high sends it from the debug side
  task automatic send(input op_e op, input logic inf, input int wa,
                      input logic [31:0] d, input logic src);
    cmd_s c;
    c = '{valid: 1'b1, op: op, info: inf, waddr: wa[WADDR_W-1:0], wdata: d};
    @(posedge sys_clk);
    if (src) begin
      dbg_cmd <= c;
    end else begin
      sw_cmd <= c;
    end
    @(posedge sys_clk);
    sw_cmd.valid  <= 1'b0;
    dbg_cmd.valid <= 1'b0;
  endtask : send

  // count busy cycles up to the done pulse
  task automatic wait_done(input int n);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (done !== 1'b1 && k < 2000) begin
      `CHK("busy", 1'b1, busy)
      k++;
      @(posedge sys_clk);
    end
    `CHK("op cycles", n, k)
  endtask : wait_done

  // word read with the answer due in one cycle
  task automatic rd_chk(input int wa, input logic inf, input logic d, input logic [31:0] e);
    mst.read({15'h0000, inf, wa[13:0], 2'b00}, d, q, w);
    `CHK("hrdata", e, q)
    `CHK("read waits", 0, w)
    `CHK("hresp", 1'b0, hresp)
  endtask : rd_chk

  // lock word left erased or cleared decides debug access after reset
  task automatic do_reset(input logic lk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("core_rst held", 1'b1, core_rst)
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("core_rst", 1'b0, core_rst)
    `CHK("dbg_en", ~lk, dbg_en)
  endtask : do_reset

  task automatic t_program;
    send(OP_PROG, 1'b0, 256, 32'h12345678, 1'b0);
    wait_done(PROG_CYC);
    send(OP_PROG, 1'b0, 256, 32'hFF00FF0F, 1'b0);
    wait_done(PROG_CYC);
    rd_chk(256, 1'b0, 1'b0, 32'h12005608);
    // second command lands while busy and must vanish
    send(OP_PROG, 1'b0, 257, 32'h00000000, 1'b0);
    send(OP_PROG, 1'b0, 258, 32'h00000000, 1'b0);
    wait_done(PROG_CYC - 2);
    rd_chk(258, 1'b0, 1'b0, ERASED_WORD);
    // read issued during a program stalls until the result is there
    send(OP_PROG, 1'b0, 259, 32'h0F0F0F0F, 1'b0);
    mst.read(32'h0000040C, 1'b0, q, w);
    `CHK("stalled", 1'b1, w > 0)
    `CHK("busy at serve", 1'b0, busy)
    `CHK("stalled data", 32'h0F0F0F0F, q)
  endtask : t_program

  task automatic t_page;
    int          pa [3];
    logic [31:0] pd [3];
    pa = '{127, 128, 300};
    pd = '{32'h11111111, 32'h22222222, 32'h33333333};
    foreach (pa[i]) begin
      send(OP_PROG, 1'b0, pa[i], pd[i], 1'b0);
      wait_done(PROG_CYC);
    end
    send(OP_PAGE_ERASE, 1'b0, 128, 32'h00000000, 1'b0);
    wait_done(ERASE_SHORT);
    rd_chk(127, 1'b0, 1'b0, pd[0]);
    rd_chk(128, 1'b0, 1'b0, ERASED_WORD);
    rd_chk(255, 1'b0, 1'b0, ERASED_WORD);
    rd_chk(300, 1'b0, 1'b0, pd[2]);
  endtask : t_page

  task automatic t_lock;
    send(OP_PROG, 1'b0, 400, 32'hA5A5A5A5, 1'b1);
    wait_done(PROG_CYC);
    rd_chk(400, 1'b0, 1'b1, 32'hA5A5A5A5);
    send(OP_PROG, 1'b0, LAST_W, 32'h00000000, 1'b0);
    wait_done(PROG_CYC);
    do_reset(1'b1);
    send(OP_PROG, 1'b0, 401, 32'h00000000, 1'b1);
    repeat (2) @(posedge sys_clk);
    `CHK("locked debug cmd", 1'b0, busy)
    rd_chk(401, 1'b0, 1'b0, ERASED_WORD);
    rd_chk(256, 1'b0, 1'b1, 32'h00000000);
  endtask : t_lock

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // main sequence: fresh array reads as locked until mass erased
  initial begin
    repeat (10) @(posedge sys_clk);
    do_reset(1'b1);
    // info content is unknown at power-up; programming zeros makes it known
    send(OP_PROG, 1'b1, 0, 32'h00000000, 1'b0);
    wait_done(PROG_CYC);
    rd_chk(0, 1'b1, 1'b0, 32'h00000000);
    send(OP_MASS_ERASE, 1'b0, 0, 32'h00000000, 1'b0);
    wait_done(ERASE_SHORT);
    rd_chk(0, 1'b0, 1'b0, ERASED_WORD);
    rd_chk(LAST_W, 1'b0, 1'b0, ERASED_WORD);
    rd_chk(0, 1'b1, 1'b0, 32'h00000000);
    do_reset(1'b0);
    t_program();
    t_page();
    t_lock();
    give_verdict();
  end

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #(50 * 30000);
    n_mismatch++;
    give_verdict();
  end
endmodule : flash_program_erase_ctrl_bench
